// ==== kp_serial_ctrl.sv ====
// serial control port, output driver and integrate/hold logic of the knock processor
`timescale 1ns/10ps
// What this block does
// R1: control word selects one of two channels
// R2: channel change applies within microseconds
// R3: integrate/hold high integrates, low holds
// R4: integrator output held while hold low
// R5: transfers only while chip select low
// R6: chip select high tristates serial output
// R7: prescaler word LSB one forces tristate
// R8: diagnostic mode overrides output enable
// R9: words are exactly eight bits
// R10: data captured on falling serial clock
// R11: test input low enters diagnostic mode
// R12: apply word after eight bits, select high
module kp_serial_ctrl (
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic                         sckClk,
  input  wire logic                         csN,
  input  wire logic                         serIn,
  output logic                              serOut,
  output logic                              serOutOe,
  input  wire logic                         testN,
  input  wire logic                         diagOut,
  input  wire logic                         diagOe,
  input  wire logic                         intHold,
  input  wire logic [kp_pkg::KP_INT_W-1:0]  integratorIn,
  output logic      [kp_pkg::KP_INT_W-1:0]  integrator_output,
  output logic                              integrateMode,
  output logic                              chanSel,
  output logic                              soTristate,
  output logic                              diagMode
);
  import kp_pkg::*;

  logic [3:0]     bitCnt   = KP_BITS_ZERO; // no rst_n in the link domain, so power up cleared
  logic [7:0]     shiftReg = '0; // defined echo before the first full word arrives
  kp_word_s       rxWord   = '0;
  logic           rxTgl    = 1'b0;
  logic           tooLong  = 1'b0;
  logic           csS1, csS2, csS3;
  logic           tglS1, tglS2, seenTgl;
  logic           longS1, longS2;
  logic           outS1, outS2;
  logic           testS1, testS2;
  logic           intS1, intS2;
  logic           csRise;
  logic           newWord;
  kp_so_e         soState;

  // link domain: bit count cleared by the frame's own select, so a stopped clock is harmless
  always_ff @(negedge sckClk or posedge csN) begin
    if (csN) begin // R5
      bitCnt <= KP_BITS_ZERO;
    end else if (bitCnt != KP_BITS_OVER) begin
      bitCnt <= bitCnt + KP_BITS_ONE;
    end
  end

  // shift in on the falling edge, msb first
  always_ff @(negedge sckClk) begin
    shiftReg <= {shiftReg[6:0], serIn}; // R10
  end

  // eighth bit completes a word; toggle tells the core domain
  always_ff @(negedge sckClk) begin
    if (!csN && bitCnt == (KP_BITS_FULL - KP_BITS_ONE)) begin // R9
      rxWord <= kp_word_s'({shiftReg[6:0], serIn});
      rxTgl  <= ~rxTgl;
    end
  end

  // a ninth bit marks the frame bad; first bit of a frame clears it
  always_ff @(negedge sckClk) begin
    if (!csN && bitCnt == KP_BITS_ZERO) begin
      tooLong <= 1'b0;
    end else if (!csN && bitCnt == KP_BITS_FULL) begin // R9
      tooLong <= 1'b1;
    end
  end

  // pin and cross-domain synchronisers, two flops each, plus a third on select for its edge
  always_ff @(posedge core_clk) begin
    csS1   <= csN;
    csS2   <= csS1;
    csS3   <= csS2;
    tglS1  <= rxTgl;
    tglS2  <= tglS1;
    longS1 <= tooLong;
    longS2 <= longS1;
    outS1  <= shiftReg[7];
    outS2  <= outS1;
    testS1 <= testN;
    testS2 <= testS1;
    intS1  <= intHold;
    intS2  <= intS1;
  end

  // rising select ends the frame; word is stable because the link clock stopped
  assign csRise  = csS2 && !csS3;
  assign newWord = (tglS2 != seenTgl) && !longS2;

  // remember which completed word was last consumed
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      seenTgl <= tglS2;
    end else if (csRise) begin // R12
      seenTgl <= tglS2;
    end
  end

  // apply channel word at end of frame, a few core cycles after select rises
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chanSel <= KP_CHAN_RST;
    end else if (csRise && newWord && rxWord.cmd == KP_CMD_CHAN) begin // R12
      chanSel <= rxWord.payload[KP_FLAG_BIT]; // R1 R2
    end
  end

  // prescaler word lsb programs the output tristate
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      soTristate <= KP_TRIST_RST;
    end else if (csRise && newWord && rxWord.cmd == KP_CMD_PRESC) begin // R12
      soTristate <= rxWord.payload[KP_FLAG_BIT]; // R7
    end
  end

  // test low means diagnostic
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      diagMode <= 1'b0;
    end else begin
      diagMode <= !testS2; // R11
    end
  end

  // output driver state, diagnostic first, then prescaler bit, then select
  always_comb begin
    if (diagMode) begin
      soState = KP_SO_DIAG; // R8
    end else if (soTristate || csS2) begin
      soState = KP_SO_OFF; // R6 R7
    end else begin
      soState = KP_SO_ACTIVE;
    end
  end

  // registered pin drive; adds a few ns after select but keeps the pin glitch free
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      serOut   <= 1'b0;
      serOutOe <= 1'b0;
    end else begin
      case (soState)
        KP_SO_DIAG: begin
          serOut   <= diagOut; // R8
          serOutOe <= diagOe;
        end
        KP_SO_ACTIVE: begin
          serOut   <= outS2;
          serOutOe <= 1'b1;
        end
        KP_SO_OFF: begin
          serOut   <= 1'b0;
          serOutOe <= 1'b0; // R6 R7
        end
        default: begin
          serOut   <= 1'b0;
          serOutOe <= 1'b0;
        end
      endcase
    end
  end

  // integrate/hold mode flag
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      integrateMode <= 1'b0;
    end else begin
      integrateMode <= intS2; // R3
    end
  end

  // sample and hold of the integrator level
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      integrator_output <= KP_INT_RST;
    end else if (integrateMode) begin // R3
      integrator_output <= integratorIn;
    end // hold otherwise R4
  end

  // checks, all in the core domain
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_CS_TRISTATE: assert property (!diagMode && csS2 |=> !serOutOe) // R6
    else $error("serial output driven while deselected");
  AST_PRESC_TRISTATE: assert property (!diagMode && soTristate |=> !serOutOe) // R7
    else $error("serial output driven while tristate bit set");
  AST_ACTIVE: assert property (!diagMode && !soTristate && !csS2 |=> serOutOe && serOut == $past(outS2)) // R7
    else $error("serial output not active when selected");
  AST_DIAG_OVERRIDE: assert property (diagMode |=> serOutOe == $past(diagOe) && serOut == $past(diagOut)) // R8
    else $error("diagnostic did not own the serial output");
  AST_DIAG_ENTRY: assert property ($fell(testS2) |=> diagMode) // R11
    else $error("test low did not enter diagnostic mode");
  AST_INTEGRATE: assert property (integrateMode |=> integrator_output == $past(integratorIn)) // R3
    else $error("integrator output not tracking");
  AST_HOLD: assert property (!integrateMode |=> $stable(integrator_output)) // R4
    else $error("integrator output moved during hold");
  AST_APPLY_AT_END: assert property ($changed(chanSel) |-> $past(csRise) && $past(csS2)) // R12
    else $error("channel changed outside end of frame");
  AST_CHAN_APPLY: assert property (csRise && newWord && rxWord.cmd == KP_CMD_CHAN // R1
                                   |=> chanSel == $past(rxWord.payload[KP_FLAG_BIT]))
    else $error("channel word not applied");
  AST_SWITCH_FAST: assert property ($rose(csS2) && newWord && rxWord.cmd == KP_CMD_CHAN // R2
                                    |=> chanSel == $past(rxWord.payload[KP_FLAG_BIT]))
    else $error("end of frame not seen in time");

  COV_CHAN: cover property (csRise && newWord && rxWord.cmd == KP_CMD_CHAN);
  COV_PRESC: cover property (csRise && newWord && rxWord.cmd == KP_CMD_PRESC);
  COV_DIAG: cover property (diagMode && serOutOe);
  COV_HOLD: cover property ($fell(integrateMode));
endmodule : kp_serial_ctrl

// ==== kp_pkg.sv ====
// shared constants and types for the knock processor serial control block
package kp_pkg;
  // serial word geometry
  localparam int           KP_WORD_W     = 8;
  localparam logic [3:0]   KP_BITS_FULL  = 4'h8;
  localparam logic [3:0]   KP_BITS_OVER  = 4'h9;
  localparam logic [3:0]   KP_BITS_ZERO  = 4'h0;
  localparam logic [3:0]   KP_BITS_ONE   = 4'h1;
  // command field in the top two bits of each word
  localparam logic [1:0]   KP_CMD_PRESC  = 2'h1;
  localparam logic [1:0]   KP_CMD_CHAN   = 2'h3;
  localparam int           KP_FLAG_BIT   = 0;
  // reset values of settings
  localparam logic         KP_CHAN_RST   = 1'b0;
  localparam logic         KP_TRIST_RST  = 1'b0;
  // width of the digitised integrator level
  localparam int           KP_INT_W      = 10;
  localparam logic [9:0]   KP_INT_RST    = 10'h000;

  // received word as command plus payload
  typedef struct packed {
    logic [1:0] cmd;
    logic [5:0] payload;
  } kp_word_s;

  // state of the serial output driver
  typedef enum logic [1:0] {
    KP_SO_OFF,
    KP_SO_ACTIVE,
    KP_SO_DIAG
  } kp_so_e;
endpackage : kp_pkg

// ==== kp_host.sv ====
// host model acting as serial master toward the control port
`timescale 1ns/10ps
module kp_host (
  output logic sckClk,
  output logic csN,
  output logic serIn
);
  // clock idles low, released data line sits at its pull-up level
  initial begin
    sckClk = 1'b0;
    csN    = 1'b1;
    serIn  = 1'b1;
  end
  // one frame msb first; n other than 8 only for refusal cases
  task automatic send(input logic [8:0] w, input int n);
    #7 csN = 1'b0;
    // data moves on the rising edge so the falling capture never races it
    for (int i = n - 1; i >= 0; i--) begin
      #40 sckClk = 1'b1;
      serIn = w[i];
      #40 sckClk = 1'b0;
    end
    #40 csN = 1'b1;
    serIn = 1'b1;
  endtask : send
endmodule : kp_host

// ==== test_knock_processor_serial_control.sv ====
// self-checking bench for the knock processor serial control block
`timescale 1ns/10ps
module test_knock_processor_serial_control;
  import kp_pkg::*;
  logic       coreClk = 1'b0, rstN = 1'b0, testN = 1'b1, diagOut = 1'b0, diagOe = 1'b0, intHold = 1'b0;
  logic [9:0] integratorIn = 10'h000, integOut;
  logic       sckClk, csN, serIn, serOut, serOutOe, integrateMode, chanSel, soTristate, diagMode;
  int         badCount = 0, nChecks = 0;

  kp_host u_host (.sckClk(sckClk), .csN(csN), .serIn(serIn));
  kp_serial_ctrl u_dut (.core_clk(coreClk), .rst_n(rstN), .sckClk(sckClk), .csN(csN), .serIn(serIn),
    .serOut(serOut), .serOutOe(serOutOe), .testN(testN), .diagOut(diagOut), .diagOe(diagOe),
    .intHold(intHold), .integratorIn(integratorIn), .integrator_output(integOut),
    .integrateMode(integrateMode), .chanSel(chanSel), .soTristate(soTristate), .diagMode(diagMode));

  always #2.5 coreClk = ~coreClk;

  task automatic w(input int n);
    repeat (n) @(negedge coreClk);
  endtask : w

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // frame then enough core cycles for the settings to land
  task automatic tx(input logic [8:0] v, input int n);
    u_host.send(v, n);
    w(8);
  endtask : tx

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // channel word; output driven only inside the frame, setting waits for its end
  task automatic t_chan(input logic [8:0] v, input logic oe, input logic oldCh);
    fork
      tx(v, 8);
      begin
        w(80);
        chk(serOutOe, oe);
        chk(chanSel, oldCh);
      end
    join
    chk(serOutOe, 1'b0);
    chk(chanSel, v[0]);
    $display("channel word %h done", v);
  endtask : t_chan

  // short, long and unknown words must change nothing
  task automatic t_refuse;
    tx(9'h0C1, 7);
    chk(chanSel, 1'b0);
    tx(9'h183, 9);
    chk(chanSel, 1'b0);
    tx(9'h081, 8);
    chk({soTristate, chanSel}, 2'b00);
    $display("refusal test done");
  endtask : t_refuse

  task automatic t_diag;
    testN = 1'b0;
    diagOe = 1'b1;
    diagOut = 1'b1;
    w(8);
    chk(diagMode, 1'b1);
    chk({serOutOe, serOut}, 2'b11);
    diagOe = 1'b0;
    w(4);
    chk(serOutOe, 1'b0);
    testN = 1'b1;
    w(8);
    chk(diagMode, 1'b0);
    $display("diagnostic test done");
  endtask : t_diag

  task automatic t_hold;
    integratorIn = 10'h155;
    intHold = 1'b1;
    w(8);
    chk({integrateMode, integOut}, 11'h555);
    intHold = 1'b0;
    w(8);
    integratorIn = 10'h2AA; // hold must ignore this
    w(4);
    chk({integrateMode, integOut}, 11'h155);
    $display("integrate hold test done");
  endtask : t_hold

  // watchdog sized well above the expected run
  initial begin
    #200000;
    badCount++;
    tally_and_finish;
  end

  initial begin
    w(16);
    rstN = 1'b1;
    w(4);
    chk({chanSel, soTristate, serOutOe, diagMode, integrateMode, integOut}, 15'h0000);
    $display("reset test done");
    t_refuse;
    t_chan(9'h0C1, 1'b1, 1'b0);
    t_chan(9'h0C0, 1'b1, 1'b1);
    tx(9'h041, 8);
    chk(soTristate, 1'b1);
    t_chan(9'h0C1, 1'b0, 1'b0);
    tx(9'h040, 8);
    t_chan(9'h0C0, 1'b1, 1'b1);
    t_diag;
    t_hold;
    tally_and_finish;
  end
endmodule : test_knock_processor_serial_control
